// *** dv/ahr_master.sv ***
`timescale 1ns/100ps
`default_nettype none

// ********************************
// Two-wire bus master model
// ********************************
module ahr_master (
  input  wire logic scl_oe, // Device holds clock low
  input  wire logic sda_oe, // Device holds data low
  output logic      scl_w,  // Clock wire level
  output logic      sda_w   // Data wire level
);
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;

  // Released lines go high through the pull-ups
  assign scl_w = scl_m & ~scl_oe;
  assign sda_w = sda_m & ~sda_oe;

  // Release clock and wait out any stretch; the bench watchdog bounds a hang
  task automatic rise;
    scl_m = 1'b1;
    wait (scl_w === 1'b1);
  endtask : rise

  // Low phase kept long so the device's sync delay never meets a data change
  task automatic pulse(input logic b, output logic s);
    #6 sda_m = b;
    #16 rise();
    #10 s = sda_w;
    scl_m = 1'b0;
  endtask : pulse

  // Start or repeated start
  task automatic start_c;
    #6 sda_m = 1'b1;
    #16 rise();
    #10 sda_m = 1'b0;
    #12 scl_m = 1'b0;
  endtask : start_c

  // Stop leaves both lines high; the clock then stands still
  task automatic stop_c;
    #6 sda_m = 1'b0;
    #16 rise();
    #10 sda_m = 1'b1;
  endtask : stop_c

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask : wbyte

  // Ends with acknowledge, or not-acknowledge when last
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(last, s);
  endtask : rbyte
endmodule : ahr_master

`default_nettype wire

// *** dv/tb_adc_i2c_hs_read_control.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_adc_i2c_hs_read_control;
  localparam logic [4:0] TID    = 5'h15; // Type prefix, value arbitrary
  localparam logic [7:0] ADDR_W = {TID, 2'b10, 1'b0};
  localparam logic [7:0] ADDR_R = {TID, 2'b10, 1'b1};
  localparam logic [7:0] ADDR_X = {TID, 2'b01, 1'b0};

  logic        ref_clk      = 1'b0;
  logic        resetn       = 1'b0;
  logic        conv_ready   = 1'b0;
  logic [11:0] conv_code    = 12'h000;
  int          stretch_cnt  = 0;
  int          fail_count   = 0;
  int          comparisons  = 0;
  wire logic   scl_w;
  wire logic   sda_w;
  wire logic   scl_oe;
  wire logic   sda_oe;
  wire logic   conv_run;
  wire logic   hs_mode;
  wire logic   scl_o;
  wire logic   sda_o;

  always #2 ref_clk = ~ref_clk;

  ahr_slave #(.TYPE_ID(TID)) u_dut (
    .ref_clk         (ref_clk),
    .resetn          (resetn),
    .scl_i           (scl_w),
    .scl_o           (scl_o),
    .scl_oe          (scl_oe),
    .sda_i           (sda_w),
    .sda_o           (sda_o),
    .sda_oe          (sda_oe),
    .select_pin_high (1'b1),
    .select_pin_low  (1'b0),
    .conv_ready      (conv_ready),
    .conv_code       (conv_code),
    .conv_run        (conv_run),
    .hs_mode         (hs_mode)
  );

  ahr_master u_mst (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_w(scl_w), .sda_w(sda_w));

  // Converter stand-in: slow enough that a high-speed read must be stretched
  always
  begin
    wait (conv_run === 1'b1);
    repeat (100) @(posedge ref_clk);
    #1 conv_ready = 1'b1;
    wait (conv_run !== 1'b1);
    @(posedge ref_clk);
    #1 conv_ready = 1'b0;
  end

  // Cycles of clock stretching; scenarios compare counts taken before and after
  always @(posedge ref_clk)
    if (scl_oe === 1'b1)
      stretch_cnt <= stretch_cnt + 1;

  // ********************************
  // Checking and scenarios
  // ********************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic fs_second_cmd;
    logic a;
    int   s0;
    s0 = stretch_cnt;
    u_mst.start_c();
    u_mst.wbyte(ADDR_W, a);
    u_mst.wbyte(8'h1f, a);
    chk("cmd ack", 16'h1, 16'(a));
    chk("conv_run", 16'h1, 16'(conv_run));
    u_mst.wbyte(8'h00, a);
    chk("cmd2 ack", 16'h0, 16'(a));
    #40 chk("conv_run", 16'h0, 16'(conv_run));
    chk("fs stretch", 16'h0, 16'(stretch_cnt - s0));
    u_mst.stop_c();
  endtask : fs_second_cmd

  task automatic bad_cmd;
    logic       a;
    logic [7:0] bad [3];
    bad = '{8'h20, 8'h40, 8'h80};
    u_mst.start_c();
    u_mst.wbyte(ADDR_X, a);
    chk("addr ack", 16'h0, 16'(a));
    foreach (bad[i])
    begin
      u_mst.start_c();
      u_mst.wbyte(ADDR_W, a);
      u_mst.wbyte(bad[i], a);
      chk("bad ack", 16'h0, 16'(a));
      #40 chk("conv_run", 16'h0, 16'(conv_run));
    end
    u_mst.stop_c();
  endtask : bad_cmd

  task automatic stop_abort;
    logic a;
    u_mst.start_c();
    u_mst.wbyte(ADDR_W, a);
    u_mst.wbyte(8'h00, a);
    chk("conv_run", 16'h1, 16'(conv_run));
    u_mst.stop_c();
    #40 chk("conv_run", 16'h0, 16'(conv_run));
  endtask : stop_abort

  // Enter high-speed mode, then two single-code reads joined by repeated start
  task automatic hs_read;
    logic        a;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [11:0] codes [2];
    int          s0;
    codes = '{12'ha5c, 12'h3c7};
    u_mst.start_c();
    u_mst.wbyte(8'h08, a);
    chk("mcode ack", 16'h0, 16'(a));
    foreach (codes[i])
    begin
      @(posedge ref_clk);
      #1 conv_code = codes[i];
      u_mst.start_c();
      #40 chk("hs_mode", 16'h1, 16'(hs_mode));
      s0 = stretch_cnt;
      u_mst.wbyte(ADDR_W, a);
      chk("addr ack", 16'h1, 16'(a));
      u_mst.wbyte(8'h00, a);
      chk("cmd ack", 16'h1, 16'(a));
      chk("conv_run", 16'h1, 16'(conv_run));
      u_mst.start_c();
      chk("stretch", 16'h1, 16'(stretch_cnt > s0));
      chk("pin drive", 16'h0, 16'({scl_o, sda_o}));
      u_mst.wbyte(ADDR_R, a);
      #40 chk("conv_run", 16'h0, 16'(conv_run));
      u_mst.rbyte(1'b0, b0);
      u_mst.rbyte(1'b1, b1);
      chk("code", {4'h0, codes[i]}, {b0, b1});
    end
    u_mst.start_c();
    #40 chk("hs_mode", 16'h1, 16'(hs_mode));
    u_mst.stop_c();
    #40 chk("hs_mode", 16'h0, 16'(hs_mode));
  endtask : hs_read

  task automatic tally_and_finish;
    $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence; bus idle after reset so the straps settle first
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1 resetn = 1'b1;
    repeat (8) @(posedge ref_clk);
    fs_second_cmd();
    bad_cmd();
    stop_abort();
    repeat (200) @(posedge ref_clk);
    hs_read();
    tally_and_finish();
  end

  // Watchdog: the sequence needs well under a quarter of this
  initial
  begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_adc_i2c_hs_read_control

`default_nettype wire

// *** hw/ahr_pkg.sv ***
// ****************************************************************
// Shared constants and types for the converter serial read slave
// ****************************************************************
package ahr_pkg;

  // Converter result and serial byte geometry
  localparam int          AHR_CODE_W     = 12;
  localparam logic [3:0]  AHR_BYTE_BITS  = 4'h8;
  localparam logic [3:0]  AHR_LAST_BIT   = 4'h7;
  // Count of bits already shifted in when command bit 5 is on the wire
  localparam logic [3:0]  AHR_BIT5_CNT   = 4'h2;

  // Reserved master code prefix that announces high-speed mode
  localparam logic [4:0]  AHR_MCODE_PFX  = 5'h01;

  // Strap capture: cycles after reset release before select pins are frozen
  localparam logic [1:0]  AHR_STRAP_CYC  = 2'h3;

  // Reset values
  localparam logic [7:0]  AHR_SH_RST     = 8'h00;
  localparam logic [11:0] AHR_CODE_RST   = 12'h000;
  localparam logic [3:0]  AHR_CNT_RST    = 4'h0;

  // Transfer states, Gray coded along idle, address, ack, data
  typedef enum logic [2:0] {
    AHR_IDLE = 3'b000,
    AHR_ADDR = 3'b001,
    AHR_ACK  = 3'b011,
    AHR_RX   = 3'b010,
    AHR_HOLD = 3'b110,
    AHR_TX   = 3'b111,
    AHR_MACK = 3'b101
  } ahr_state_type;

  // Inputs that arrive from outside the ref_clk domain
  typedef struct packed {
    logic conv_ready;
    logic sel_hi;
    logic sel_lo;
    logic scl;
    logic sda;
  } ahr_async_type;

endpackage : ahr_pkg

// *** hw/ahr_slave.sv ***
`timescale 1ns/100ps
`default_nettype none

module ahr_slave
  import ahr_pkg::*;
#(
  parameter logic [4:0] TYPE_ID = 5'h0b  // Device type prefix, value arbitrary
)
(
  input  wire logic        ref_clk,          // Block clock, 250 MHz
  input  wire logic        resetn,           // Async reset, active low
  input  wire logic        scl_i,            // Serial clock pin level
  output logic             scl_o,            // Serial clock drive value
  output logic             scl_oe,           // High while pulling clock low
  input  wire logic        sda_i,            // Serial data pin level
  output logic             sda_o,            // Serial data drive value
  output logic             sda_oe,           // High while pulling data low
  input  wire logic        select_pin_high,  // Address select strap, upper
  input  wire logic        select_pin_low,   // Address select strap, lower
  input  wire logic        conv_ready,       // Converter result valid, async
  input  wire logic [11:0] conv_code,        // Converter result, stable while ready
  output logic             conv_run,         // Converter powered and converting
  output logic             hs_mode           // High-speed bus mode active
);

  // ****************************************************************
  // Input synchronisation and bus event detection
  // ****************************************************************
  ahr_async_type raw_w;
  ahr_async_type syn_w;
  logic          scl_p_q;
  logic          sda_p_q;
  logic          rdy_p_q;

  assign raw_w = '{conv_ready: conv_ready, sel_hi: select_pin_high, sel_lo: select_pin_low,
                   scl: scl_i, sda: sda_i};

  ahr_sync u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .async_i (raw_w),
    .sync_o  (syn_w)
  );

  // Previous synced levels for edge finding
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      rdy_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= syn_w.scl;
      sda_p_q <= syn_w.sda;
      rdy_p_q <= syn_w.conv_ready;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic rdy_rise;

  // Data moving while clock stays high marks START or STOP
  assign scl_rise = syn_w.scl & ~scl_p_q;
  assign scl_fall = ~syn_w.scl & scl_p_q;
  assign start_ev = syn_w.scl & scl_p_q & sda_p_q & ~syn_w.sda;
  assign stop_ev  = syn_w.scl & scl_p_q & ~sda_p_q & syn_w.sda;
  // The two synchroniser cycles after ready let the code bus settle before capture
  assign rdy_rise = syn_w.conv_ready & ~rdy_p_q;

  // ****************************************************************
  // Strap capture of the select pins
  // ****************************************************************
  logic [1:0] sel_q;
  logic [1:0] strap_cnt_q;

  // Pins are followed for a few cycles after reset, then frozen
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_q       <= 2'h0;
      strap_cnt_q <= 2'h0;
    end
    else if (strap_cnt_q != AHR_STRAP_CYC)
    begin
      sel_q       <= {syn_w.sel_hi, syn_w.sel_lo};
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Selects the byte of a result to send: zeros and top nibble first
  function automatic logic [7:0] out_byte(input logic [11:0] code, input logic low);
    out_byte = low ? code[7:0] : {4'h0, code[11:8]};
  endfunction : out_byte

  ahr_state_type state_q;
  ahr_state_type nxt_q;
  logic [7:0]    sh_q;
  logic [3:0]    cnt_q;
  logic          ack_q;
  logic          mack_q;
  logic          low_q;
  logic          nack_cmd_q;
  logic          cmd_seen_q;
  logic          hs_arm_q;
  logic [11:0]   code_q;
  logic          fresh_q;

  logic byte_end;
  logic addr_hit;
  logic mcode_hit;
  logic cmd_ok;
  logic read_hit;
  logic cmd_end;
  logic cmd_bit5;
  logic ack_fall;

  assign byte_end  = scl_fall && (cnt_q == AHR_BYTE_BITS);
  assign addr_hit  = (sh_q[7:3] == TYPE_ID) && (sh_q[2:1] == sel_q);
  assign mcode_hit = (sh_q[7:3] == AHR_MCODE_PFX) && !hs_mode;
  assign cmd_ok    = (sh_q[7:5] == 3'h0) && !cmd_seen_q;
  assign read_hit  = (state_q == AHR_ADDR) && byte_end && addr_hit && sh_q[0];
  assign cmd_end   = (state_q == AHR_RX) && byte_end;
  assign cmd_bit5  = (state_q == AHR_RX) && scl_rise && (cnt_q == AHR_BIT5_CNT)
                     && (sh_q[1:0] == 2'h0) && !syn_w.sda && !cmd_seen_q;
  assign ack_fall  = (state_q == AHR_ACK) && scl_fall;

  // ****************************************************************
  // Transfer state machine and pin drivers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= AHR_IDLE;
      nxt_q   <= AHR_IDLE;
      sh_q    <= AHR_SH_RST;
      cnt_q   <= AHR_CNT_RST;
      ack_q   <= 1'b0;
      mack_q  <= 1'b0;
      low_q   <= 1'b0;
      sda_oe  <= 1'b0;
      scl_oe  <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_q <= AHR_IDLE;
      sda_oe  <= 1'b0;
      scl_oe  <= 1'b0;
    end
    else if (start_ev)
    begin
      state_q <= AHR_ADDR;
      cnt_q   <= AHR_CNT_RST;
      sda_oe  <= 1'b0;
      scl_oe  <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        AHR_IDLE: ;
        AHR_ADDR, AHR_RX:
        begin
          if (scl_rise)
          begin
            sh_q  <= {sh_q[6:0], syn_w.sda};
            cnt_q <= cnt_q + 4'h1;
          end
          else if (byte_end)
          begin
            // Master code is never acknowledged, so it goes idle too
            if (state_q == AHR_ADDR)
            begin
              ack_q <= addr_hit;
              nxt_q <= sh_q[0] ? AHR_TX : AHR_RX;
            end
            else
            begin
              ack_q <= cmd_ok;
              nxt_q <= hs_mode ? AHR_HOLD : AHR_RX;
            end
            sda_oe  <= (state_q == AHR_ADDR) ? addr_hit : cmd_ok;
            state_q <= AHR_ACK;
          end
        end
        AHR_ACK:
        begin
          if (scl_fall)
          begin
            cnt_q <= AHR_CNT_RST;
            if (!ack_q)
            begin
              sda_oe  <= 1'b0;
              state_q <= AHR_IDLE;
            end
            else if (nxt_q == AHR_TX)
            begin
              low_q   <= 1'b0;
              sh_q    <= out_byte(code_q, 1'b0);
              sda_oe  <= 1'b1;  // First bit of the high byte is always zero
              state_q <= AHR_TX;
            end
            else
            begin
              sda_oe  <= 1'b0;
              scl_oe  <= (nxt_q == AHR_HOLD);
              state_q <= nxt_q;
            end
          end
        end
        AHR_HOLD:
        begin
          // Clock is released only once a fresh result is held
          if (fresh_q)
          begin
            scl_oe  <= 1'b0;
            state_q <= AHR_RX;
          end
        end
        AHR_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_q == AHR_LAST_BIT)
            begin
              sda_oe  <= 1'b0;
              state_q <= AHR_MACK;
            end
            else
            begin
              sda_oe <= ~sh_q[6];
              sh_q   <= {sh_q[6:0], 1'b0};
              cnt_q  <= cnt_q + 4'h1;
            end
          end
        end
        AHR_MACK:
        begin
          if (scl_rise)
            mack_q <= ~syn_w.sda;
          else if (scl_fall)
          begin
            cnt_q <= AHR_CNT_RST;
            if (mack_q)
            begin
              // Beyond the first code the stream only repeats
              low_q   <= ~low_q;
              sh_q    <= out_byte(code_q, ~low_q);
              sda_oe  <= low_q | ~code_q[7];  // Top bit of the next byte
              state_q <= AHR_TX;
            end
            else
              state_q <= AHR_IDLE;
          end
        end
      endcase
    end
  end

  // Drive values are fixed low: the pins are open drain
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
      scl_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Conversion control and result capture
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      conv_run   <= 1'b0;
      code_q     <= AHR_CODE_RST;
      fresh_q    <= 1'b0;
      cmd_seen_q <= 1'b0;
      nack_cmd_q <= 1'b0;
    end
    else
    begin
      if (stop_ev)
        conv_run <= 1'b0;
      else if (read_hit)
        conv_run <= 1'b0;
      else if (ack_fall && nack_cmd_q)
        conv_run <= 1'b0;
      else if (cmd_bit5)
        conv_run <= 1'b1;
      // One result per read: code is frozen once the converter stops
      if (cmd_bit5)
        fresh_q <= 1'b0;
      else if (conv_run && rdy_rise)
      begin
        code_q  <= conv_code;
        fresh_q <= 1'b1;
      end
      // A valid command is tracked until read, STOP or the next command
      if (stop_ev || read_hit)
        cmd_seen_q <= 1'b0;
      else if (cmd_end)
        cmd_seen_q <= cmd_ok;
      if (cmd_end)
        nack_cmd_q <= !cmd_ok;
      else if (ack_fall || stop_ev)
        nack_cmd_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Bus speed mode
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hs_mode  <= 1'b0;
      hs_arm_q <= 1'b0;
    end
    else if (stop_ev)
    begin
      hs_mode  <= 1'b0;
      hs_arm_q <= 1'b0;
    end
    else if (start_ev && hs_arm_q)
    begin
      hs_mode  <= 1'b1;
      hs_arm_q <= 1'b0;
    end
    else if ((state_q == AHR_ADDR) && byte_end && mcode_hit)
      hs_arm_q <= 1'b1;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_stop_conv_end: assert property (stop_ev |=> !conv_run)
    else $error("conversion survived a STOP");
  a_stop_hs_exit: assert property (stop_ev |=> !hs_mode ##1 !hs_mode)
    else $error("high-speed mode survived a STOP");
  a_read_conv_end: assert property (read_hit && !stop_ev |=> !conv_run)
    else $error("read address did not end conversion");
  a_bit5_conv_start: assert property (cmd_bit5 && !stop_ev |=> conv_run && !fresh_q)
    else $error("command bit 5 did not start conversion");
  a_stretch_hold: assert property (scl_oe && !fresh_q && !stop_ev && !start_ev |=> scl_oe)
    else $error("clock released before conversion finished");
  a_stretch_hs_only: assert property ($rose(scl_oe) |-> hs_mode && $past(state_q) == AHR_ACK)
    else $error("clock stretched outside high-speed command");
  a_cmd_nack: assert property (cmd_end && !cmd_ok && !stop_ev && !start_ev |=> !sda_oe)
    else $error("refused command was acknowledged");
  a_nack_powerdown: assert property (ack_fall && nack_cmd_q && !stop_ev |=> !conv_run)
    else $error("second command did not power down converter");
  a_high_nibble: assert property (state_q == AHR_TX && !low_q && cnt_q < 4'h4 |-> sda_oe)
    else $error("upper nibble of first byte not zero");
  a_code_frozen: assert property (state_q == AHR_TX |=> $stable(code_q))
    else $error("result changed during readout");
  a_hs_entry: assert property (start_ev && hs_arm_q && !stop_ev |=> hs_mode)
    else $error("master code and repeated START missed");

endmodule : ahr_slave

`default_nettype wire

// *** hw/ahr_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for the asynchronous bus, strap and ready inputs
// ****************************************************************
module ahr_sync
  import ahr_pkg::*;
(
  input  wire logic          ref_clk,  // Block clock
  input  wire logic          resetn,   // Async reset, active low
  input  wire ahr_async_type async_i,  // Raw asynchronous inputs
  output var  ahr_async_type sync_o    // Synchronised copy
);

  ahr_async_type meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '{default: 1'b1};
      sync_o <= '{default: 1'b1};
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : ahr_sync

`default_nettype wire
